// file: hdl/cwc_pkg.sv
// package: register map, field layout, reset values and mode codes of the waveform control block
package cwc_pkg;
  // register indices (printed offsets are not multiples of four)
  localparam logic [11:0] CWC_IDX_CTRL0   = 12'h610;
  localparam logic [11:0] CWC_IDX_DBR     = 12'h60E;
  localparam logic [11:0] CWC_IDX_DBF     = 12'h60F;
  localparam logic [11:0] CWC_IDX_CLKSEL  = 12'h60C;
  localparam logic [11:0] CWC_IDX_ISM     = 12'h60D;
  localparam logic [11:0] CWC_IDX_SHUT    = 12'h612;
  localparam logic [11:0] CWC_IDX_STEER   = 12'h614;
  localparam logic [11:0] CWC_IDX_IRQ_ST  = 12'h620;
  localparam logic [11:0] CWC_IDX_IRQ_MSK = 12'h621;
  localparam logic [13:0] CWC_ADDR_CTRL0   = {CWC_IDX_CTRL0, 2'b00};
  localparam logic [13:0] CWC_ADDR_DBR     = {CWC_IDX_DBR, 2'b00};
  localparam logic [13:0] CWC_ADDR_DBF     = {CWC_IDX_DBF, 2'b00};
  localparam logic [13:0] CWC_ADDR_CLKSEL  = {CWC_IDX_CLKSEL, 2'b00};
  localparam logic [13:0] CWC_ADDR_ISM     = {CWC_IDX_ISM, 2'b00};
  localparam logic [13:0] CWC_ADDR_SHUT    = {CWC_IDX_SHUT, 2'b00};
  localparam logic [13:0] CWC_ADDR_STEER   = {CWC_IDX_STEER, 2'b00};
  localparam logic [13:0] CWC_ADDR_IRQ_ST  = {CWC_IDX_IRQ_ST, 2'b00};
  localparam logic [13:0] CWC_ADDR_IRQ_MSK = {CWC_IDX_IRQ_MSK, 2'b00};
  // control register fields
  localparam int CWC_BIT_EN   = 7;
  localparam int CWC_BIT_LOAD = 6;
  localparam int CWC_MODE_LSB = 0;
  localparam int CWC_MODE_W   = 3;
  // shutdown register fields
  localparam int CWC_BIT_SHUTDOWN = 7;
  localparam int CWC_BIT_RESTART  = 6;
  localparam int CWC_BIT_OVR_BD   = 4;
  localparam int CWC_BIT_OVR_AC   = 2;
  // interrupt status bits
  localparam int CWC_IRQ_LOADED = 0;
  localparam int CWC_IRQ_SHUT   = 1;
  localparam int CWC_IRQ_W      = 2;
  // widths
  localparam int CWC_DB_W = 6;
  // reset values
  localparam logic [7:0] CWC_RST_CTRL0 = 8'h00;
  localparam logic [7:0] CWC_RST_SHUT  = 8'h80;
  localparam logic [7:0] CWC_RST_ZERO  = 8'h00;
  // output modes
  typedef enum logic [2:0] {
    CWC_MODE_ASYNC_STEER = 3'h0,
    CWC_MODE_SYNC_STEER  = 3'h1,
    CWC_MODE_FULL_FWD    = 3'h2,
    CWC_MODE_FULL_REV    = 3'h3,
    CWC_MODE_HALF        = 3'h4,
    CWC_MODE_PUSH_PULL   = 3'h5,
    CWC_MODE_RSVD6       = 3'h6,
    CWC_MODE_RSVD7       = 3'h7
  } cwc_mode_t;
endpackage : cwc_pkg

// file: hdl/cwc_sync_if.sv
// interface: synchronised data input and its edge events toward the control logic
`timescale 1ns/1ps
interface cwc_sync_if;
  logic level;  // filtered input level
  logic rise;   // one-cycle rising event
  logic fall;   // one-cycle falling event
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : cwc_sync_if

// file: hdl/cwc_sync.sv
// module: three-stage pin synchroniser with agreement filter and edge events
`timescale 1ns/1ps
module cwc_sync (
  input  wire logic sys_clk,  // block clock
  input  wire logic rst_n,    // synchronous reset, active low
  input  wire logic pin,      // asynchronous input
  cwc_sync_if.src   evt       // filtered level and edges
);
  import cwc_pkg::*;

  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       lvl_reg;
  logic       lvl_next;
  logic       rise_reg;
  logic       rise_next;
  logic       fall_reg;
  logic       fall_next;

  // stage 0 feeds only stage 1; level changes once stages 1 and 2 agree
  always_comb begin
    sh_next   = {sh_reg[1:0], pin};
    lvl_next  = lvl_reg;
    if (sh_reg[1] == sh_reg[2]) begin
      lvl_next = sh_reg[2];
    end
    rise_next = lvl_next & ~lvl_reg;
    fall_next = ~lvl_next & lvl_reg;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sh_reg   <= 3'h0;
      lvl_reg  <= 1'b0;
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
    end else begin
      sh_reg   <= sh_next;
      lvl_reg  <= lvl_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
    end
  end

  assign evt.level = lvl_reg;
  assign evt.rise  = rise_reg;
  assign evt.fall  = fall_reg;
endmodule : cwc_sync

// file: hdl/cwc_ctrl.sv
// module: enable, buffer load, mode select, shutdown start-up and sleep clock request of the waveform generator
//
// Operation
// - runs from own selected clock during sleep
// - keep oscillator on when enabled, active, selected
// - cpu idles, oscillator and generator keep running
// - auto-restart clears shutdown status after enable
// - enable bit 7, read-write, resets zero
// - load counts on rise after fall after request
// - request zero leaves active counts unchanged
// - request ignored in write that sets enable
// - mode 000 async steering, 001 sync steering
// - mode 010 forward, 011 reverse full bridge
// - 100 half bridge, 101 push-pull, rest reserved
// - disabled count write loads active buffer immediately
`timescale 1ns/1ps
module cwc_ctrl
  import cwc_pkg::*;
#(
  parameter int DB_W = cwc_pkg::CWC_DB_W  // dead-band count width
) (
  input  wire logic            sys_clk,        // block clock
  input  wire logic            rst_n,          // synchronous reset, active low
  input  wire logic [13:0]     bus_addr,       // byte address
  input  wire logic [7:0]      bus_wdata,      // write data
  input  wire logic            bus_wr,         // write strobe
  input  wire logic            bus_rd,         // read strobe
  output logic      [7:0]      bus_rdata,      // read data, cycle after strobe
  input  wire logic            data_in,        // selected data input, asynchronous
  input  wire logic            shutdown_in,    // combined shutdown source, active high level
  input  wire logic            source_active,  // selected input source is running
  input  wire logic            sleep_req,      // chip enters sleep
  output logic                 gen_enable,     // generator enabled
  output logic [DB_W-1:0]      rise_db_active, // active rising dead-band count
  output logic [DB_W-1:0]      fall_db_active, // active falling dead-band count
  output cwc_pkg::cwc_mode_t   mode,           // output mode
  output logic                 mode_reserved,  // reserved mode selected
  output logic                 shutdown_state, // shutdown in effect
  output logic                 clk_sel_hfosc,  // generator clock is internal oscillator
  output logic                 hfosc_keep,     // keep oscillator running in sleep
  output logic                 cpu_idle_only,  // cpu idles while generator runs
  output logic                 irq             // interrupt, active high level
);
  // ****************************************************************
  // synchronised data input
  // ****************************************************************
  cwc_sync_if din();
  cwc_sync u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin     (data_in),
    .evt     (din)
  );

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [7:0]            ctrl_reg,   ctrl_next;
  logic [DB_W-1:0]       dbr_reg,    dbr_next;
  logic [DB_W-1:0]       dbf_reg,    dbf_next;
  logic [DB_W-1:0]       dbr_act_reg, dbr_act_next;
  logic [DB_W-1:0]       dbf_act_reg, dbf_act_next;
  logic                  armed_reg,  armed_next;
  logic [7:0]            shut_reg,   shut_next;
  logic                  clksel_reg, clksel_next;
  logic [7:0]            ism_reg,    ism_next;
  logic [7:0]            steer_reg,  steer_next;
  logic [CWC_IRQ_W-1:0]  ist_reg,    ist_next;
  logic [CWC_IRQ_W-1:0]  imsk_reg,   imsk_next;
  logic [7:0]            rdata_reg,  rdata_next;
  logic                  irq_reg,    irq_next;
  logic                  keep_reg,   keep_next;
  logic                  idle_reg,   idle_next;
  logic                  wr_ctrl, wr_dbr, wr_dbf, wr_shut;
  logic                  transfer;
  logic                  shut_set;

  assign wr_ctrl = bus_wr && (bus_addr == CWC_ADDR_CTRL0);
  assign wr_dbr  = bus_wr && (bus_addr == CWC_ADDR_DBR);
  assign wr_dbf  = bus_wr && (bus_addr == CWC_ADDR_DBF);
  assign wr_shut = bus_wr && (bus_addr == CWC_ADDR_SHUT);
  // transfer fires on the first rise after the arming fall
  assign transfer = ctrl_reg[CWC_BIT_LOAD] && armed_reg && din.rise;

  // ****************************************************************
  // control register, buffer load and dead-band buffers
  // ****************************************************************
  always_comb begin
    ctrl_next    = ctrl_reg;
    dbr_next     = dbr_reg;
    dbf_next     = dbf_reg;
    dbr_act_next = dbr_act_reg;
    dbf_act_next = dbf_act_reg;
    armed_next   = armed_reg;
    if (wr_ctrl) begin
      ctrl_next[CWC_BIT_EN] = bus_wdata[CWC_BIT_EN];
      ctrl_next[CWC_MODE_LSB +: CWC_MODE_W] = bus_wdata[CWC_MODE_LSB +: CWC_MODE_W];
      // request only sticks when enable already stood before this write
      if (bus_wdata[CWC_BIT_LOAD] && ctrl_reg[CWC_BIT_EN] && bus_wdata[CWC_BIT_EN]) begin
        ctrl_next[CWC_BIT_LOAD] = 1'b1;
        if (!ctrl_reg[CWC_BIT_LOAD]) begin
          armed_next = 1'b0;
        end
      end else if (!bus_wdata[CWC_BIT_LOAD] || !bus_wdata[CWC_BIT_EN]) begin
        ctrl_next[CWC_BIT_LOAD] = 1'b0;
      end
    end
    if (wr_dbr) begin
      dbr_next = bus_wdata[DB_W-1:0];
    end
    if (wr_dbf) begin
      dbf_next = bus_wdata[DB_W-1:0];
    end
    // disabled writes pass straight into the active buffers
    if (!ctrl_reg[CWC_BIT_EN]) begin
      if (wr_dbr) begin
        dbr_act_next = bus_wdata[DB_W-1:0];
      end
      if (wr_dbf) begin
        dbf_act_next = bus_wdata[DB_W-1:0];
      end
    end
    if (ctrl_reg[CWC_BIT_LOAD] && din.fall) begin
      armed_next = 1'b1;
    end
    // completion clears the request and wins over a same-cycle control write that sets it
    if (transfer) begin
      dbr_act_next = dbr_reg;
      dbf_act_next = dbf_reg;
      ctrl_next[CWC_BIT_LOAD] = 1'b0;
      armed_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg    <= CWC_RST_CTRL0;
      dbr_reg     <= '0;
      dbf_reg     <= '0;
      dbr_act_reg <= '0;
      dbf_act_reg <= '0;
      armed_reg   <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      dbr_reg     <= dbr_next;
      dbf_reg     <= dbf_next;
      dbr_act_reg <= dbr_act_next;
      dbf_act_reg <= dbf_act_next;
      armed_reg   <= armed_next;
    end
  end

  // ****************************************************************
  // shutdown status, start-up from shutdown, auto-restart
  // ****************************************************************
  // start-up is from shutdown, so the status bit resets high
  always_comb begin
    shut_next = shut_reg;
    shut_set  = 1'b0;
    if (wr_shut) begin
      shut_next[6:0] = bus_wdata[6:0];
      shut_next[CWC_BIT_SHUTDOWN] = bus_wdata[CWC_BIT_SHUTDOWN] | shutdown_in;
      shut_set = bus_wdata[CWC_BIT_SHUTDOWN] & ~shut_reg[CWC_BIT_SHUTDOWN];
    end
    // restart waits for source removal and the module enable
    if (shut_reg[CWC_BIT_RESTART] && ctrl_reg[CWC_BIT_EN] && !shutdown_in && !wr_shut) begin
      shut_next[CWC_BIT_SHUTDOWN] = 1'b0;
    end
    // a live source always wins over any clear
    if (shutdown_in) begin
      shut_set = shut_set | ~shut_reg[CWC_BIT_SHUTDOWN];
      shut_next[CWC_BIT_SHUTDOWN] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      shut_reg <= CWC_RST_SHUT;
    end else begin
      shut_reg <= shut_next;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  always_comb begin
    clksel_next = clksel_reg;
    ism_next    = ism_reg;
    steer_next  = steer_reg;
    imsk_next   = imsk_reg;
    if (bus_wr && bus_addr == CWC_ADDR_CLKSEL) begin
      clksel_next = bus_wdata[0];
    end
    if (bus_wr && bus_addr == CWC_ADDR_ISM) begin
      ism_next = {3'h0, bus_wdata[4:0]};
    end
    if (bus_wr && bus_addr == CWC_ADDR_STEER) begin
      steer_next = bus_wdata;
    end
    if (bus_wr && bus_addr == CWC_ADDR_IRQ_MSK) begin
      imsk_next = bus_wdata[CWC_IRQ_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      clksel_reg <= 1'b0;
      ism_reg    <= CWC_RST_ZERO;
      steer_reg  <= CWC_RST_ZERO;
      imsk_reg   <= '0;
    end else begin
      clksel_reg <= clksel_next;
      ism_reg    <= ism_next;
      steer_reg  <= steer_next;
      imsk_reg   <= imsk_next;
    end
  end

  // ****************************************************************
  // interrupts, sleep clock request, read port
  // ****************************************************************
  always_comb begin
    ist_next = ist_reg;
    if (bus_wr && bus_addr == CWC_ADDR_IRQ_ST) begin
      ist_next = ist_reg & ~bus_wdata[CWC_IRQ_W-1:0];
    end
    // set wins over a same-cycle clear
    if (transfer) begin
      ist_next[CWC_IRQ_LOADED] = 1'b1;
    end
    if (shut_set) begin
      ist_next[CWC_IRQ_SHUT] = 1'b1;
    end
    irq_next = |(ist_next & imsk_next);
    // generator clock is local, so only the oscillator needs holding
    keep_next = ctrl_next[CWC_BIT_EN] && source_active && clksel_next;
    idle_next = keep_next && sleep_req;
    rdata_next = 8'h00;
    if (bus_rd) begin
      case (bus_addr)
        CWC_ADDR_CTRL0:   rdata_next = {ctrl_reg[7:6], 3'h0, ctrl_reg[2:0]};
        CWC_ADDR_DBR:     rdata_next = {{(8-DB_W){1'b0}}, dbr_reg};
        CWC_ADDR_DBF:     rdata_next = {{(8-DB_W){1'b0}}, dbf_reg};
        CWC_ADDR_CLKSEL:  rdata_next = {7'h00, clksel_reg};
        CWC_ADDR_ISM:     rdata_next = ism_reg;
        CWC_ADDR_SHUT:    rdata_next = shut_reg;
        CWC_ADDR_STEER:   rdata_next = steer_reg;
        CWC_ADDR_IRQ_ST:  rdata_next = {6'h00, ist_reg};
        CWC_ADDR_IRQ_MSK: rdata_next = {6'h00, imsk_reg};
        default:          rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ist_reg   <= '0;
      irq_reg   <= 1'b0;
      keep_reg  <= 1'b0;
      idle_reg  <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ist_reg   <= ist_next;
      irq_reg   <= irq_next;
      keep_reg  <= keep_next;
      idle_reg  <= idle_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // outputs, all from flip-flops except mode_reserved, which ANDs mode bits 2 and 1
  // ****************************************************************
  assign bus_rdata      = rdata_reg;
  assign gen_enable     = ctrl_reg[CWC_BIT_EN];
  assign rise_db_active = dbr_act_reg;
  assign fall_db_active = dbf_act_reg;
  assign mode           = cwc_mode_t'(ctrl_reg[CWC_MODE_LSB +: CWC_MODE_W]);
  assign mode_reserved  = ctrl_reg[2] & ctrl_reg[1];
  assign shutdown_state = shut_reg[CWC_BIT_SHUTDOWN];
  assign clk_sel_hfosc  = clksel_reg;
  assign hfosc_keep     = keep_reg;
  assign cpu_idle_only  = idle_reg;
  assign irq            = irq_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_load_same_write;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_ctrl && !ctrl_reg[CWC_BIT_EN] && !ctrl_reg[CWC_BIT_LOAD]) |=> !ctrl_reg[CWC_BIT_LOAD];
  endproperty
  a_load_same_write: assert property (p_load_same_write) else $error("load set with enable");

  property p_hold_active;
    @(posedge sys_clk) disable iff (!rst_n)
      (!ctrl_reg[CWC_BIT_LOAD] && ctrl_reg[CWC_BIT_EN] && !wr_ctrl) |=> $stable(dbr_act_reg) && $stable(dbf_act_reg);
  endproperty
  a_hold_active: assert property (p_hold_active) else $error("active counts changed");

  property p_transfer;
    @(posedge sys_clk) disable iff (!rst_n)
      transfer |=> (dbr_act_reg == $past(dbr_reg)) && !ctrl_reg[CWC_BIT_LOAD];
  endproperty
  a_transfer: assert property (p_transfer) else $error("transfer failed");

  property p_direct_load;
    @(posedge sys_clk) disable iff (!rst_n)
      (wr_dbf && !ctrl_reg[CWC_BIT_EN]) |=> fall_db_active == $past(bus_wdata[DB_W-1:0]);
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("disabled write not direct");

  property p_enable;
    @(posedge sys_clk) disable iff (!rst_n)
      wr_ctrl |=> gen_enable == $past(bus_wdata[CWC_BIT_EN]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable not written");

  property p_restart;
    @(posedge sys_clk) disable iff (!rst_n)
      (shut_reg[CWC_BIT_RESTART] && ctrl_reg[CWC_BIT_EN] && !shutdown_in && !wr_shut) |=> !shutdown_state;
  endproperty
  a_restart: assert property (p_restart) else $error("auto-restart missed");

  property p_keep;
    @(posedge sys_clk) disable iff (!rst_n)
      hfosc_keep |-> $past(gen_enable) || gen_enable;
  endproperty
  a_keep: assert property (p_keep) else $error("oscillator held while disabled");

  property p_idle;
    @(posedge sys_clk) disable iff (!rst_n)
      cpu_idle_only |-> hfosc_keep;
  endproperty
  a_idle: assert property (p_idle) else $error("idle without oscillator");

  property p_mode_rsvd;
    @(posedge sys_clk) disable iff (!rst_n)
      mode_reserved |-> (mode == CWC_MODE_RSVD6 || mode == CWC_MODE_RSVD7);
  endproperty
  a_mode_rsvd: assert property (p_mode_rsvd) else $error("reserved flag wrong");
endmodule : cwc_ctrl

// file: verif/cwc_src_model.sv
// model: data input source that drives one low pulse on command
`timescale 1ns/1ps
module cwc_src_model #(
  parameter int LOW_CYC = 6  // cycles the data line stays low
) (
  input  wire logic sys_clk,   // block clock
  input  wire logic rst_n,     // synchronous reset, active low
  input  wire logic go,        // start one low pulse
  output logic      data_out   // data line toward the block
);
  // ****************************************
  // pulse timing
  // ****************************************
  logic [7:0] cnt_reg;
  // idles high so that a pulse is a fall followed by a rise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg  <= 8'h00;
      data_out <= 1'b1;
    end else if (go) begin
      cnt_reg  <= 8'(LOW_CYC);
      data_out <= 1'b0;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg  <= cnt_reg - 8'h01;
      data_out <= (cnt_reg == 8'h01);  // rise when the count runs out
    end
  end
endmodule // cwc_src_model

// file: verif/complementary_waveform_control_bench.sv
// testbench: register, load, mode, shutdown and sleep checks of the control block
`timescale 1ns/1ps
module complementary_waveform_control_bench;
  import cwc_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic          sys_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [13:0]   bus_addr = 14'h0000;
  logic [7:0]    bus_wdata = 8'h00;
  logic          bus_wr = 1'b0;
  logic          bus_rd = 1'b0;
  logic [7:0]    bus_rdata;
  logic          data_in;
  logic          shutdown_in = 1'b0;
  logic          source_active = 1'b0;
  logic          sleep_req = 1'b0;
  logic          go = 1'b0;
  logic          gen_enable, mode_reserved, shutdown_state;
  logic          clk_sel_hfosc, hfosc_keep, cpu_idle_only, irq;
  logic [5:0]    rise_db, fall_db;
  cwc_mode_t     mode;
  int            failures = 0;
  int            total_checks = 0;
  logic [7:0]    rv;
  logic [5:0]    r1, f1, r2, f2;

  always #5 sys_clk = ~sys_clk;  // 100 MHz

  cwc_ctrl i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .data_in(data_in),
    .shutdown_in(shutdown_in), .source_active(source_active), .sleep_req(sleep_req),
    .gen_enable(gen_enable), .rise_db_active(rise_db), .fall_db_active(fall_db),
    .mode(mode), .mode_reserved(mode_reserved), .shutdown_state(shutdown_state),
    .clk_sel_hfosc(clk_sel_hfosc), .hfosc_keep(hfosc_keep),
    .cpu_idle_only(cpu_idle_only), .irq(irq)
  );
  cwc_src_model i_src (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .data_out(data_in));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one-cycle write strobe; returns after the taking edge has landed
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  // data stand only in the cycle after the strobe, so sample right then
  task automatic rd(input logic [13:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    stop_test();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hF2E4B0C0));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk("shut_state", 8'(shutdown_state), 8'h01);
    chk("enable", 8'(gen_enable), 8'h00);
    rd(CWC_ADDR_CTRL0, rv);
    chk("ctrl_rst", rv, CWC_RST_CTRL0);
    rd(14'h3FFC, rv);
    chk("unmapped", rv, 8'h00);
    // every mode code, reserved ones flagged
    for (int m = 0; m < 8; m++) begin
      wr(CWC_ADDR_CTRL0, 8'(m));
      chk("mode", 8'(mode), 8'(m));
      chk("mode_rsv", 8'(mode_reserved), 8'(m >= 6));
      rd(CWC_ADDR_CTRL0, rv);
      chk("mode_rd", rv, 8'(m));
    end
    // setup order: disable, levels, steering, counts, clock, enable
    wr(CWC_ADDR_CTRL0, 8'h00);
    wr(CWC_ADDR_SHUT, 8'h94);
    wr(CWC_ADDR_STEER, 8'h0F);
    r1 = 6'($urandom);
    f1 = 6'($urandom);
    wr(CWC_ADDR_DBR, 8'(r1));
    wr(CWC_ADDR_DBF, 8'(f1));
    chk("rise_now", 8'(rise_db), 8'(r1));
    chk("fall_now", 8'(fall_db), 8'(f1));
    wr(CWC_ADDR_CLKSEL, 8'h01);
    wr(CWC_ADDR_CTRL0, 8'hC4);
    rd(CWC_ADDR_CTRL0, rv);
    chk("load_same_wr", rv, 8'h84);
    chk("enable_on", 8'(gen_enable), 8'h01);
    // sleep keep-alive of the internal oscillator
    source_active <= 1'b1;
    cyc(3);
    chk("hf_keep", 8'({hfosc_keep, clk_sel_hfosc}), 8'h03);
    sleep_req <= 1'b1;
    cyc(3);
    chk("cpu_idle", 8'(cpu_idle_only), 8'h01);
    source_active <= 1'b0;
    cyc(3);
    chk("hf_drop", 8'(hfosc_keep), 8'h00);
    sleep_req <= 1'b0;
    source_active <= 1'b1;
    // pending counts wait for a fall then a rise of the data line
    r2 = r1 ^ 6'(1 + $urandom % 63);
    f2 = f1 ^ 6'(1 + $urandom % 63);
    wr(CWC_ADDR_DBR, 8'(r2));
    wr(CWC_ADDR_DBF, 8'(f2));
    wr(CWC_ADDR_CTRL0, 8'hC4);
    rd(CWC_ADDR_CTRL0, rv);
    chk("load_set", rv, 8'hC4);
    cyc(8);
    chk("rise_held", 8'(rise_db), 8'(r1));
    chk("fall_held", 8'(fall_db), 8'(f1));
    go <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    for (int i = 0; i < 40 && rise_db === r1; i++) cyc(1);
    chk("rise_load", 8'(rise_db), 8'(r2));
    chk("fall_load", 8'(fall_db), 8'(f2));
    rd(CWC_ADDR_CTRL0, rv);
    chk("load_clr", rv, 8'h84);
    // loaded event: sticky, masked, then cleared by writing one
    rd(CWC_ADDR_IRQ_ST, rv);
    chk("irq_st", rv & 8'h01, 8'h01);
    chk("irq_masked", 8'(irq), 8'h00);
    wr(CWC_ADDR_IRQ_MSK, 8'h01);
    chk("irq_on", 8'(irq), 8'h01);
    wr(CWC_ADDR_IRQ_ST, 8'h01);
    chk("irq_off", 8'(irq), 8'h00);
    // auto-restart leaves shutdown by itself once enabled
    wr(CWC_ADDR_SHUT, 8'hD4);
    cyc(3);
    chk("restart", 8'(shutdown_state), 8'h00);
    // without restart a shutdown holds until software clears it
    wr(CWC_ADDR_SHUT, 8'h14);
    shutdown_in <= 1'b1;
    cyc(2);
    shutdown_in <= 1'b0;
    cyc(3);
    chk("shut_held", 8'(shutdown_state), 8'h01);
    rd(CWC_ADDR_IRQ_ST, rv);
    chk("irq_shut", rv, 8'h02);
    wr(CWC_ADDR_SHUT, 8'h14);
    chk("shut_clr", 8'(shutdown_state), 8'h00);
    stop_test();
  end
endmodule // complementary_waveform_control_bench
